/* File: src/flash_seq_pkg.sv */
// Constants shared by the serial flash command sequencer.
// Assumes a host that drives chip select, the serial clock and four data lines.
package flash_seq_pkg;
	// Command opcodes.
	localparam logic [7:0] OP_WRAP_SET = 8'h77;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_QUAD_PROG = 8'h32;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	// Byte counts of well-formed frames; the byte counter saturates at 7.
	localparam logic [2:0] LEN_OPCODE_ONLY = 3'h1;
	localparam logic [2:0] LEN_ADDR_CMD = 3'h4;
	localparam logic [2:0] LEN_WRAP_CMD = 3'h5;
	localparam logic [2:0] LEN_PROG_MIN = 3'h5;
	localparam logic [2:0] LEN_SAT = 3'h7;
	// Wrap byte fields.
	localparam int WRAP_DIS_POS = 4;
	localparam int WRAP_SIZE_LO = 5;
	localparam int WRAP_SIZE_HI = 6;
	localparam logic WRAP_DIS_RESET = 1'b1;
	localparam logic [1:0] WRAP_SIZE_RESET = 2'h0;
	localparam logic [23:0] WRAP_BASE_LEN = 24'h000008;
	// Array geometry.
	localparam logic [24:0] PAGE_BYTES = 25'h0000100;
	localparam logic [24:0] SECTOR_BYTES = 25'h0001000;
	localparam logic [24:0] BLOCK32_BYTES = 25'h0008000;
	localparam logic [24:0] BLOCK64_BYTES = 25'h0010000;
	localparam logic [16:0] BLOCK64_COUNT = 17'h00100;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// Status byte bit positions shifted out by the status read.
	localparam int STAT_BUSY_POS = 0;
	localparam int STAT_WEL_POS = 1;
	localparam int STAT_PROT_ERR_POS = 5;
	localparam int STAT_ERASE_ERR_POS = 6;
	// Serial assembly steps.
	localparam logic [2:0] STEP_SINGLE = 3'h1;
	localparam logic [2:0] STEP_QUAD = 3'h4;
	typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE} op_state_t;
endpackage

/* File: src/flash_cmd_seq.sv */
// Command sequencer of a serial NOR flash: wrap setup, page programs, erases and latch.
// Assumes the host keeps chip select high for at least three clk cycles between frames.
// Functional notes
// RQ1: Wrap command 77h, 24 dummy, wrap byte.
// RQ2: Wrap byte bits 7 and 3..0 ignored.
// RQ3: Host sets quad enable before wrap command.
// RQ4: Disable bit off selects 8/16/32/64 byte section.
// RQ5: Later quad reads wrap inside aligned section.
// RQ6: Wrap disable resets to one on reset.
// RQ7: Wrap length survives quad mode, changeable there.
// RQ8: Page program 02h, address, 1..256 bytes.
// RQ9: Program into protected page is ignored.
// RQ10: Operation starts only on proper chip select rise.
// RQ11: While busy only status read is accepted.
// RQ12: Page pointer wraps; last 256 bytes kept.
// RQ13: Unaddressed bytes kept; program only clears bits.
// RQ14: Quad program 32h needs quad enable, latch.
// RQ15: Erase sets ones over sector or block.
// RQ16: Sector erase 20h plus address, needs latch.
// RQ17: Block erase 52h or D8h, needs latch.
// RQ18: Chip erase C7h or 60h, needs latch.
// RQ19: Protected chip erase refused, both errors set.
// RQ20: Write enable sets latch; completion clears it.
// RQ21: Program and erase refused without latch.
// RQ22: Busy flag high during erase, low after.
// RQ23: Status read accepted at any time.
// RQ24: Write disable 04h clears the latch.
// RQ25: Truncated program or erase frames are discarded.
`timescale 1ns/1ps
module flash_cmd_seq #(
	parameter int ARRAY_AW = 24
) (
	input wire logic clk, // System clock, 125 MHz.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire logic sclk, // Serial clock from the host, runs only in frames.
	input wire logic cs_n, // Chip select pin, active low.
	input wire logic [3:0] io_in, // Data lines in; line 0 is the single input.
	output logic io1_out, // Serial status output on line 1.
	output logic io1_oe_n, // Line 1 drive enable, low while driving.
	input wire logic quad_enable_bit, // Quad enable configuration level.
	input wire logic [3:0] block_protect_bits, // Protection level, top-down in 64 KB blocks.
	input wire logic quad_command_mode, // Device is in quad command mode.
	input wire logic sw_reset, // One-cycle software reset pulse.
	input wire logic param_wrap_wr, // One-cycle read-parameter wrap update.
	input wire logic [1:0] param_wrap_len, // Wrap length code for that update.
	input wire logic err_clear, // One-cycle pulse clearing both error flags.
	input wire logic read_burst_wrap, // The current quad-mode read is a wrapped burst.
	input wire logic [23:0] read_addr, // Current read byte address.
	output logic [23:0] read_next_addr, // Next read address after wrap rules.
	input wire logic [23:0] mem_rd_addr, // Array inspection address.
	output logic [7:0] mem_rd_data, // Array inspection data, one cycle late.
	output logic write_latch_flag, // Write latch state.
	output logic op_in_progress_flag, // High while a program or erase runs.
	output logic erase_error_flag, // Sticky erase error.
	output logic protection_error_flag, // Sticky protection error.
	output logic wrap_disable_bit, // Stored wrap disable bit.
	output logic [1:0] wrap_size_bits // Stored wrap length code.
);
	// The array must hold at least one whole 64 KB block.
	if (ARRAY_AW < 16 || ARRAY_AW > 24) begin : g_bad_aw
		$error("ARRAY_AW must lie between 16 and 24");
	end

	localparam logic [24:0] ARRAY_BYTES = 25'h0000001 << ARRAY_AW;

	logic [7:0] mem [0:(1 << ARRAY_AW) - 1];
	logic [7:0] page_buf [0:255];
	logic link_rst_n;
	logic in_frame_reg, frame_tgl_reg, pp_frame_reg;
	logic [2:0] cnt_reg, byte_cnt_reg;
	logic [7:0] shift_reg, op_reg, wrap_byte_reg, ptr_reg;
	logic [23:0] addr_reg;
	logic [255:0] mask_reg;
	logic busy_s1, busy_s2;
	logic [7:0] stat_s1, stat_s2;
	logic [7:0] status_byte;

	// The link side is held in reset whenever chip select is high, so a frame
	// always starts from a clean bit count even if the host aborts mid-byte.
	assign link_rst_n = reset_n & ~cs_n;

	logic first, quad_phase, byte_done, data_byte, pp_start, stat_active;
	logic [2:0] cnt_cur, bytes_cur, cnt_next, bytes_next;
	logic [7:0] shift_next;
	assign first = ~in_frame_reg;
	assign cnt_cur = first ? 3'h0 : cnt_reg;
	assign bytes_cur = first ? 3'h0 : byte_cnt_reg;
	// Wrap setup and quad program take their later bytes as nibbles. RQ1 RQ14
	assign quad_phase = ~first && ((op_reg == flash_seq_pkg::OP_WRAP_SET && byte_cnt_reg != 3'h0)
		|| (op_reg == flash_seq_pkg::OP_QUAD_PROG && byte_cnt_reg >= flash_seq_pkg::LEN_ADDR_CMD));
	assign shift_next = quad_phase ? {shift_reg[3:0], io_in} : {shift_reg[6:0], io_in[0]};
	assign cnt_next = cnt_cur + (quad_phase ? flash_seq_pkg::STEP_QUAD : flash_seq_pkg::STEP_SINGLE);
	assign byte_done = (cnt_next == 3'h0);
	assign bytes_next = (byte_done && bytes_cur != flash_seq_pkg::LEN_SAT) ?
		bytes_cur + 3'h1 : bytes_cur;
	// Program data is only taken while idle; otherwise the buffer that the
	// running program reads would be overwritten under it. RQ11
	assign pp_start = byte_done && bytes_cur == 3'h0 && ~busy_s2 &&
		(shift_next == flash_seq_pkg::OP_PAGE_PROG || shift_next == flash_seq_pkg::OP_QUAD_PROG);
	assign data_byte = byte_done && ~first && pp_frame_reg && bytes_cur >= flash_seq_pkg::LEN_ADDR_CMD;
	assign stat_active = in_frame_reg && op_reg == flash_seq_pkg::OP_STATUS_READ &&
		byte_cnt_reg != 3'h0;

	// Frame marker; its toggle tells the clk side that a new frame happened.
	always_ff @(posedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			in_frame_reg <= 1'b0;
		end else begin
			in_frame_reg <= 1'b1;
		end
	end

	// Byte assembly. These registers survive the frame end so that the clk
	// side can read them quasi-statically while the serial clock stands still.
	always_ff @(posedge sclk or negedge reset_n) begin
		if (!reset_n) begin
			frame_tgl_reg <= 1'b0;
			cnt_reg <= 3'h0;
			byte_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
		end else begin
			frame_tgl_reg <= frame_tgl_reg ^ first;
			cnt_reg <= cnt_next;
			byte_cnt_reg <= bytes_next;
			shift_reg <= shift_next;
		end
	end

	// Opcode, address and wrap byte capture.
	always_ff @(posedge sclk or negedge reset_n) begin
		if (!reset_n) begin
			op_reg <= 8'h00;
			addr_reg <= 24'h000000;
			wrap_byte_reg <= 8'h00;
		end else if (byte_done) begin
			if (bytes_cur == 3'h0) begin
				op_reg <= shift_next;
			end
			if (bytes_cur != 3'h0 && bytes_cur < flash_seq_pkg::LEN_ADDR_CMD) begin
				addr_reg <= {addr_reg[15:0], shift_next};
			end
			if (bytes_cur == flash_seq_pkg::LEN_ADDR_CMD) begin
				wrap_byte_reg <= shift_next; // RQ1
			end
		end
	end

	// Page buffer fill: the pointer wraps within the page, so an overrun simply
	// overwrites the oldest bytes and the last 256 remain. RQ12
	always_ff @(posedge sclk or negedge reset_n) begin
		if (!reset_n) begin
			pp_frame_reg <= 1'b0;
			ptr_reg <= 8'h00;
			mask_reg <= '0;
		end else begin
			if (first) begin
				pp_frame_reg <= pp_start;
			end else if (pp_start) begin
				pp_frame_reg <= 1'b1;
			end
			if (pp_start) begin
				mask_reg <= '0;
			end else if (data_byte) begin
				mask_reg[ptr_reg] <= 1'b1; // RQ13
			end
			if (byte_done && bytes_cur == 3'h3) begin
				ptr_reg <= shift_next;
			end else if (data_byte) begin
				ptr_reg <= ptr_reg + 8'h01; // RQ12
			end
		end
	end

	always_ff @(posedge sclk) begin
		if (data_byte) begin
			page_buf[ptr_reg] <= shift_next;
		end
	end

	// Busy and status levels brought onto the serial clock.
	always_ff @(posedge sclk or negedge reset_n) begin
		if (!reset_n) begin
			busy_s1 <= 1'b0;
			busy_s2 <= 1'b0;
			stat_s1 <= 8'h00;
			stat_s2 <= 8'h00;
		end else begin
			busy_s1 <= op_in_progress_flag;
			busy_s2 <= busy_s1;
			stat_s1 <= status_byte;
			stat_s2 <= stat_s1;
		end
	end

	// Status shifts out on falling edges, most significant bit first, and
	// repeats for as long as the host keeps clocking. RQ23
	always_ff @(negedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			io1_out <= 1'b0;
			io1_oe_n <= 1'b1;
		end else begin
			io1_out <= stat_s2[3'h7 - cnt_reg]; // RQ23
			io1_oe_n <= ~stat_active;
		end
	end

	// ---- clk domain ----
	flash_seq_pkg::op_state_t state_reg, state_next;
	logic cs_s1, cs_s2, cs_s3, tgl_s1, tgl_s2, seen_tgl_reg;
	logic [23:0] cur_reg;
	logic [24:0] left_reg;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
		end else begin
			cs_s1 <= cs_n;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			tgl_s1 <= frame_tgl_reg;
			tgl_s2 <= tgl_s1;
		end
	end

	// Protection covers the top 2^(n-1) 64 KB blocks for level n.
	function automatic logic prot_hit(input logic [3:0] bp, input logic [7:0] blk);
		logic [16:0] span;
		logic [16:0] sum;
		span = 17'h00001 << (bp - 4'h1);
		sum = {9'h000, blk} + span;
		return (bp != 4'h0) && (sum >= flash_seq_pkg::BLOCK64_COUNT);
	endfunction

	logic cs_rise, fr_ok, busy, addr_prot, ce_op, er_op, op_done;
	logic exec_write_enable_cmd, exec_write_disable_cmd, exec_wrap, exec_er, exec_ce, ce_refused, exec_pp;
	logic start_erase, start_prog;
	logic [24:0] er_len;
	logic [23:0] er_base;
	assign cs_rise = cs_s2 & ~cs_s3;
	assign busy = (state_reg != flash_seq_pkg::ST_IDLE);
	// Only a frame that really clocked, ended on a byte boundary and found the
	// device idle is decoded; everything else is dropped. RQ10 RQ11 RQ25
	assign fr_ok = cs_rise && (tgl_s2 != seen_tgl_reg) && cnt_reg == 3'h0 && ~busy;
	assign addr_prot = prot_hit(block_protect_bits, addr_reg[23:16]);
	assign ce_op = op_reg == flash_seq_pkg::OP_CHIP_ERASE_A || op_reg == flash_seq_pkg::OP_CHIP_ERASE_B;
	assign er_op = op_reg == flash_seq_pkg::OP_SECTOR_ERASE ||
		op_reg == flash_seq_pkg::OP_BLOCK32_ERASE || op_reg == flash_seq_pkg::OP_BLOCK64_ERASE;
	assign exec_write_enable_cmd = fr_ok && op_reg == flash_seq_pkg::OP_WRITE_ENABLE &&
		byte_cnt_reg == flash_seq_pkg::LEN_OPCODE_ONLY; // RQ20
	assign exec_write_disable_cmd = fr_ok && op_reg == flash_seq_pkg::OP_WRITE_DISABLE &&
		byte_cnt_reg == flash_seq_pkg::LEN_OPCODE_ONLY; // RQ24
	assign exec_wrap = fr_ok && op_reg == flash_seq_pkg::OP_WRAP_SET &&
		byte_cnt_reg == flash_seq_pkg::LEN_WRAP_CMD; // RQ1
	assign exec_er = fr_ok && er_op && byte_cnt_reg == flash_seq_pkg::LEN_ADDR_CMD &&
		write_latch_flag; // RQ16 RQ17 RQ21 RQ25
	assign exec_ce = fr_ok && ce_op && byte_cnt_reg == flash_seq_pkg::LEN_OPCODE_ONLY &&
		write_latch_flag; // RQ18 RQ21
	assign ce_refused = exec_ce && block_protect_bits != 4'h0; // RQ19
	assign exec_pp = fr_ok && write_latch_flag && byte_cnt_reg >= flash_seq_pkg::LEN_PROG_MIN &&
		(op_reg == flash_seq_pkg::OP_PAGE_PROG ||
		(op_reg == flash_seq_pkg::OP_QUAD_PROG && quad_enable_bit)); // RQ8 RQ14 RQ21
	assign start_prog = exec_pp && ~addr_prot; // RQ9
	assign start_erase = (exec_er && ~addr_prot) || (exec_ce && ~ce_refused);
	// Erase range, aligned down to its own size. RQ15
	assign er_len = ce_op ? ARRAY_BYTES :
		op_reg == flash_seq_pkg::OP_SECTOR_ERASE ? flash_seq_pkg::SECTOR_BYTES :
		op_reg == flash_seq_pkg::OP_BLOCK32_ERASE ? flash_seq_pkg::BLOCK32_BYTES :
		flash_seq_pkg::BLOCK64_BYTES;
	assign er_base = ce_op ? 24'h000000 : addr_reg & ~(er_len[23:0] - 24'h000001);
	assign op_done = busy && left_reg == 25'h0000001;

	// Operation engine: one array byte per cycle.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			flash_seq_pkg::ST_IDLE: begin
				if (start_prog) begin
					state_next = flash_seq_pkg::ST_PROG;
				end else if (start_erase) begin
					state_next = flash_seq_pkg::ST_ERASE;
				end
			end
			flash_seq_pkg::ST_PROG, flash_seq_pkg::ST_ERASE: begin
				if (op_done) begin
					state_next = flash_seq_pkg::ST_IDLE;
				end
			end
			default: state_next = flash_seq_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= flash_seq_pkg::ST_IDLE;
			op_in_progress_flag <= 1'b0;
			seen_tgl_reg <= 1'b0;
			cur_reg <= 24'h000000;
			left_reg <= 25'h0000000;
		end else begin
			state_reg <= state_next;
			op_in_progress_flag <= (state_next != flash_seq_pkg::ST_IDLE); // RQ11 RQ22
			if (cs_rise) begin
				seen_tgl_reg <= tgl_s2;
			end
			if (start_prog) begin
				cur_reg <= {addr_reg[23:8], 8'h00};
				left_reg <= flash_seq_pkg::PAGE_BYTES;
			end else if (start_erase) begin
				cur_reg <= er_base;
				left_reg <= er_len;
			end else if (busy) begin
				cur_reg <= cur_reg + 24'h000001;
				left_reg <= left_reg - 25'h0000001;
			end
		end
	end

	// Programming only clears bits and skips bytes that were not sent;
	// erasing writes all ones. RQ13 RQ15
	always_ff @(posedge clk) begin
		if (state_reg == flash_seq_pkg::ST_PROG && mask_reg[cur_reg[7:0]]) begin
			mem[cur_reg[ARRAY_AW-1:0]] <= mem[cur_reg[ARRAY_AW-1:0]] & page_buf[cur_reg[7:0]];
		end else if (state_reg == flash_seq_pkg::ST_ERASE) begin
			mem[cur_reg[ARRAY_AW-1:0]] <= flash_seq_pkg::ERASED_BYTE;
		end
		mem_rd_data <= mem[mem_rd_addr[ARRAY_AW-1:0]];
	end

	// Latch, error and wrap state. Completion clears the latch; a set of an
	// error flag wins over a clear in the same cycle.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			write_latch_flag <= 1'b0;
			erase_error_flag <= 1'b0;
			protection_error_flag <= 1'b0;
			wrap_disable_bit <= flash_seq_pkg::WRAP_DIS_RESET;
			wrap_size_bits <= flash_seq_pkg::WRAP_SIZE_RESET;
		end else begin
			if (op_done) begin
				write_latch_flag <= 1'b0; // RQ20
			end else if (exec_write_enable_cmd) begin
				write_latch_flag <= 1'b1; // RQ20
			end else if (exec_write_disable_cmd) begin
				write_latch_flag <= 1'b0; // RQ24
			end
			if (ce_refused) begin
				erase_error_flag <= 1'b1; // RQ19
				protection_error_flag <= 1'b1; // RQ19
			end else if (err_clear) begin
				erase_error_flag <= 1'b0;
				protection_error_flag <= 1'b0;
			end
			if (sw_reset) begin
				wrap_disable_bit <= flash_seq_pkg::WRAP_DIS_RESET; // RQ6
				wrap_size_bits <= flash_seq_pkg::WRAP_SIZE_RESET;
			end else if (exec_wrap) begin
				wrap_disable_bit <= wrap_byte_reg[flash_seq_pkg::WRAP_DIS_POS]; // RQ2 RQ6
				wrap_size_bits <= wrap_byte_reg[flash_seq_pkg::WRAP_SIZE_HI:
					flash_seq_pkg::WRAP_SIZE_LO]; // RQ2 RQ4
			end else if (param_wrap_wr && quad_command_mode) begin
				wrap_size_bits <= param_wrap_len; // RQ7
			end
		end
	end

	// Read address stepping: in SPI mode wrap follows the disable bit, in quad
	// mode only the wrapped burst read wraps, with the same stored length.
	logic wrap_on;
	logic [23:0] wrap_mask, lin_next;
	assign wrap_on = quad_command_mode ? read_burst_wrap : ~wrap_disable_bit; // RQ5 RQ7
	assign wrap_mask = (flash_seq_pkg::WRAP_BASE_LEN << wrap_size_bits) - 24'h000001; // RQ4
	assign lin_next = read_addr + 24'h000001;
	assign status_byte = {1'b0, erase_error_flag, protection_error_flag, 3'h0,
		write_latch_flag, op_in_progress_flag};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			read_next_addr <= 24'h000000;
		end else begin
			read_next_addr <= wrap_on ? ((read_addr & ~wrap_mask) | (lin_next & wrap_mask)) :
				lin_next; // RQ5
		end
	end

	// ---- checks ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence prog_run_s;
		op_in_progress_flag [*8] ##[240:260] !op_in_progress_flag;
	endsequence

	wel_set_a: assert property (exec_write_enable_cmd && !op_done |=> write_latch_flag) // RQ20
		else $error("write enable did not set the latch");
	wel_clear_a: assert property (exec_write_disable_cmd |=> !write_latch_flag) // RQ24
		else $error("write disable did not clear the latch");
	prog_busy_a: assert property (start_prog |=> op_in_progress_flag ##1 prog_run_s) // RQ11
		else $error("program busy window wrong");
	done_wel_a: assert property ($fell(op_in_progress_flag) |-> !write_latch_flag) // RQ20
		else $error("latch still set after completion");
	busy_ignore_a: assert property (cs_rise && busy && !op_done && !sw_reset |=>
		$stable(wrap_disable_bit) &&
		$stable(wrap_size_bits) && $stable(write_latch_flag)) // RQ11
		else $error("command accepted while busy");
	ce_prot_a: assert property (ce_refused |=> erase_error_flag && protection_error_flag &&
		!op_in_progress_flag) // RQ19
		else $error("protected chip erase not refused");
	wrap_cfg_a: assert property (exec_wrap && !sw_reset |=>
		wrap_size_bits == $past(wrap_byte_reg[6:5]) &&
		wrap_disable_bit == $past(wrap_byte_reg[4])) // RQ2
		else $error("wrap byte stored wrongly");
	wrap_reset_a: assert property (sw_reset |=> wrap_disable_bit) // RQ6
		else $error("wrap disable not restored");
	no_latch_a: assert property (fr_ok && !write_latch_flag |=> !op_in_progress_flag) // RQ21
		else $error("operation started without latch");
	erase_busy_a: assert property (start_erase |=> op_in_progress_flag [*8]) // RQ22
		else $error("erase busy flag missing");
endmodule

/* File: dv/flash_host_model.sv */
// Host side of the serial link: drives chip select, the serial clock and the data lines.
// Assumes the bench calls one task at a time and keeps frames apart.
`timescale 1ns/1ps
module flash_host_model (
	output logic sclk, // Serial clock, still between frames.
	output logic cs_n, // Chip select, active low.
	output logic [3:0] io_in, // Data lines towards the device.
	input wire logic io1_out // Status bit from the device.
);
	// Lines start idle; released lines later show the inverse of their last value.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		io_in = 4'h0;
	end
	// One clock in mode 0; a single-line beat scrambles the unused lines.
	task automatic beat(input logic [3:0] v, input bit quad);
		io_in = quad ? v : {~io_in[3:1], v[0]};
		#3 sclk = 1'b1;
		#3 sclk = 1'b0;
	endtask
	// One byte, MSB first on line 0, or as two nibbles high first on all lines.
	task automatic put(input logic [7:0] b, input bit quad);
		if (quad) begin
			beat(b[7:4], 1'b1);
			beat(b[3:0], 1'b1);
		end else begin
			for (int i = 7; i >= 0; i--) begin
				beat({3'h0, b[i]}, 1'b0);
			end
		end
	endtask
	// Frames hold select low through every clock; the clock stands low outside.
	task automatic open_frame();
		cs_n = 1'b0;
		#3;
	endtask
	task automatic close_frame();
		#3 cs_n = 1'b1;
		io_in = ~io_in;
	endtask
	// Shifts the status byte in, sampling on each rising edge.
	task automatic get(output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			io_in = ~io_in;
			#3 sclk = 1'b1;
			b = {b[6:0], io1_out};
			#3 sclk = 1'b0;
		end
	endtask
endmodule

/* File: dv/serial_flash_program_erase_wrap_bench.sv */
// Self-checking bench of the flash command sequencer with a host link model.
// Assumes a shortened array of 64 KB so that long erases stay brief.
`timescale 1ns/1ps
module serial_flash_program_erase_wrap_bench;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic qe = 1'b0, sw_reset = 1'b0, err_clear = 1'b0;
	logic [3:0] bp = 4'h0;
	logic [23:0] raddr = 24'h0, maddr = 24'h0;
	wire sclk, cs_n, io1_out, io1_oe_n;
	wire [3:0] io_in;
	logic [23:0] rnext;
	logic [7:0] mdata, st;
	logic wl, busy, eerr, perr, wdis;
	logic [1:0] wsz;
	logic [31:0] rnd = 32'h9811;
	logic [7:0] exp_mem [int];
	logic [7:0] ops [4] = '{8'h02, 8'hd8, 8'hc7, 8'h60};
	int fails = 0, samples_checked = 0;
	always #4 clk = ~clk;
	flash_host_model hst (.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io1_out(io1_out));
	flash_cmd_seq #(.ARRAY_AW(16)) dut (.clk(clk), .reset_n(reset_n), .sclk(sclk),
		.cs_n(cs_n), .io_in(io_in), .io1_out(io1_out), .io1_oe_n(io1_oe_n),
		.quad_enable_bit(qe), .block_protect_bits(bp), .quad_command_mode(1'b0),
		.sw_reset(sw_reset), .param_wrap_wr(1'b0), .param_wrap_len(2'h0),
		.err_clear(err_clear), .read_burst_wrap(1'b0), .read_addr(raddr),
		.read_next_addr(rnext), .mem_rd_addr(maddr), .mem_rd_data(mdata),
		.write_latch_flag(wl), .op_in_progress_flag(busy), .erase_error_flag(eerr),
		.protection_error_flag(perr), .wrap_disable_bit(wdis), .wrap_size_bits(wsz));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Frame effects land three clk edges after select rises; six leave margin.
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic cmd(input logic [7:0] op, input int nadr, input logic [23:0] a);
		hst.open_frame();
		hst.put(op, 1'b0);
		for (int i = 0; i < nadr; i++) begin
			hst.put(a[23-8*i -: 8], 1'b0);
		end
	endtask
	task automatic fin();
		hst.close_frame();
		settle();
	endtask
	task automatic write_enable_cmd();
		cmd(8'h06, 0, 24'h0);
		fin();
	endtask
	// Bounded wait for the busy flag to fall; running out counts as a mismatch.
	task automatic wait_idle();
		int n = 0;
		while (busy !== 1'b0 && n < 70000) begin
			@(posedge clk);
			n++;
		end
		#1;
		if (n >= 70000) fails++;
	endtask
	task automatic peek(input int a, input logic [7:0] e);
		maddr = 24'(a);
		repeat (2) @(posedge clk);
		#1;
		check(mdata, e);
	endtask
	// Later bytes overwrite earlier ones at the same wrapped place, then AND in.
	task automatic prog(input logic [7:0] op, input logic [23:0] a, input int cnt);
		logic [7:0] pg [int];
		write_enable_cmd();
		cmd(op, 3, a);
		for (int i = 0; i < cnt; i++) begin
			rnd = lfsr(rnd);
			hst.put(rnd[7:0], op == 8'h32);
			pg[int'({a[23:8], a[7:0] + 8'(i)})] = rnd[7:0];
		end
		foreach (pg[k]) exp_mem[k] &= pg[k];
		fin();
		check(busy, 1);
		cmd(8'h04, 0, 24'h0);
		fin();
		check(wl, 1);
		wait_idle();
		check(wl, 0);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Watchdog sized well above the longest erase plus the frames.
	initial begin
		#800000;
		fails++;
		summarize();
	end
	initial begin
		repeat (10) @(posedge clk);
		#1 reset_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check({wl, busy, eerr, perr, wdis, wsz}, 7'h04);
		$display("reset test done");
		qe = 1'b1;
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			cmd(8'h77, 0, 24'h0);
			repeat (3) hst.put(8'h00, 1'b1);
			hst.put({rnd[7], 2'(i), 1'b0, rnd[3:0]}, 1'b1);
			fin();
			check({wdis, wsz}, {1'b0, 2'(i)});
			raddr = {rnd[23:8], 8'h7f};
			repeat (2) @(posedge clk);
			#1;
			check(rnext, raddr - 24'((8 << i) - 1));
		end
		sw_reset = 1'b1;
		@(posedge clk);
		#1 sw_reset = 1'b0;
		settle();
		check({wdis, wsz, rnext}, {3'h4, raddr + 24'h1});
		$display("wrap test done");
		cmd(8'h02, 3, 24'h0);
		hst.put(8'h00, 1'b0);
		fin();
		check(busy, 0);
		write_enable_cmd();
		cmd(8'h20, 2, 24'h0);
		fin();
		check({busy, wl}, 2'h1);
		bp = 4'h1;
		foreach (ops[i]) begin
			cmd(ops[i], (i < 2) ? 3 : 0, 24'hff0000);
			if (i == 0) hst.put(8'h00, 1'b0);
			fin();
			check({busy, wl, eerr, perr}, {2'h1, {2{i > 1}}});
			err_clear = 1'b1;
			@(posedge clk);
			#1 err_clear = 1'b0;
		end
		cmd(8'h04, 0, 24'h0);
		fin();
		check(wl, 0);
		$display("refusal test done");
		bp = 4'h0;
		write_enable_cmd();
		cmd(8'h20, 3, 24'h000123);
		fin();
		cmd(8'h05, 0, 24'h0);
		hst.get(st);
		check(io1_oe_n, 0);
		fin();
		check(st[1:0], 2'h3);
		wait_idle();
		check({busy, wl}, 2'h0);
		for (int i = 0; i < 4096; i++) exp_mem[i] = 8'hff;
		prog(8'h02, 24'h0001f0, 272);
		prog(8'h32, 24'h000204, 9);
		prog(8'h02, 24'h000206, 4);
		for (int i = 256; i < 768; i++) peek(i, exp_mem[i]);
		qe = 1'b0;
		write_enable_cmd();
		cmd(8'h32, 3, 24'h000300);
		hst.put(8'h00, 1'b1);
		fin();
		check(busy, 0);
		$display("program test done");
		cmd(8'h52, 3, 24'h008000);
		fin();
		check(busy, 1);
		wait_idle();
		peek(32'h8000, 8'hff);
		peek(32'hffff, 8'hff);
		$display("erase test done");
		summarize();
	end
endmodule
